// [hw/nt_function_status_class_regs.sv]
// Status, revision, class code and line size registers of the NT function
//
// Behaviour
// - status bit 3 mirrors pending legacy interrupt
// - status bit 4 always reads one
// - bit 8 logs poison when logging enabled
// - status bit 11 always reads zero
// - bit 12 set on completer abort completion
// - bit 13 set on unsupported request completion
// - bit 14 set on error message, enabled
// - bit 15 set on any received poison
// - unused status bits read zero, ignore writes
// - revision writable when unlocked, survives soft reset
// - class low byte reads zero
// - class sub-class byte reads 0x80
// - class base byte reads 0x06
// - line size plain storage, reset zero
// - logging enable from command bit 6
// - error reporting enable from command bit 8
`timescale 1ns/1ns
module nt_function_status_class_regs
(
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  input  wire logic                      soft_rst_in,
  input  wire nt_status_pkg::cfg_req_t   cfg_req_in,
  input  wire nt_status_pkg::txn_event_t txn_event_in,
  input  wire logic [15:0]               function_command_word_in,
  input  wire logic                      legacy_irq_pending_in,
  input  wire logic                      revision_unlock_in,
  output logic                           cfg_hit_out,
  output logic [31:0]                    cfg_rdata_out,
  output logic                           cfg_rvalid_out,
  output logic [15:0]                    function_status_word_out,
  output logic [7:0]                     line_size_hint_out
);

  // ==========================================================
  // Address decode
  logic [5:0] dw_idx;
  logic       hit_status;
  logic       hit_rev_class;
  logic       hit_line;

  assign dw_idx        = cfg_req_in.addr[7:2];
  assign hit_status    = dw_idx == nt_status_pkg::STATUS_OFS[7:2];
  assign hit_rev_class = dw_idx == nt_status_pkg::REVISION_OFS[7:2];
  assign hit_line      = dw_idx == nt_status_pkg::LINE_OFS[7:2];
  assign cfg_hit_out   = hit_status | hit_rev_class | hit_line;

  // Byte lanes of each register within its dword
  localparam int unsigned STS_LANE = 32'(nt_status_pkg::STATUS_OFS[1:0]);
  localparam int unsigned REV_LANE =
    32'(nt_status_pkg::REVISION_OFS[1:0]);
  localparam int unsigned CLS_LANE = 32'(nt_status_pkg::CLASS_OFS[1:0]);
  localparam int unsigned LINE_LANE = 32'(nt_status_pkg::LINE_OFS[1:0]);

  logic        wr_status_hi;
  logic        wr_rev;
  logic        wr_line;
  logic [15:0] wr_status_val;

  // Only the upper status byte holds clearable flags
  assign wr_status_hi  = cfg_req_in.wr & hit_status
                         & cfg_req_in.be[STS_LANE + 1];
  assign wr_status_val = cfg_req_in.wdata[STS_LANE*8 +: 16];
  assign wr_rev        = cfg_req_in.wr & hit_rev_class
                         & cfg_req_in.be[REV_LANE];
  assign wr_line       = cfg_req_in.wr & hit_line
                         & cfg_req_in.be[LINE_LANE];

  // ==========================================================
  // Enables taken from the command word
  logic poison_log_en;
  logic syserr_en;

  assign poison_log_en =
    function_command_word_in[nt_status_pkg::CMD_POISON_LOG_BIT];
  assign syserr_en =
    function_command_word_in[nt_status_pkg::CMD_SYSERR_BIT];

  // ==========================================================
  // Set conditions for each sticky flag
  logic [nt_status_pkg::NUM_FLAGS-1:0] flag_set;
  logic [nt_status_pkg::NUM_FLAGS-1:0] flag_clr;
  logic [nt_status_pkg::NUM_FLAGS-1:0] flag_q;

  localparam int unsigned FLAG_POS [nt_status_pkg::NUM_FLAGS] = '{
    nt_status_pkg::REQ_POISON_BIT,
    nt_status_pkg::ABORT_RX_BIT,
    nt_status_pkg::UNSUP_RX_BIT,
    nt_status_pkg::SYSERR_BIT,
    nt_status_pkg::POISON_DET_BIT
  };

  always_comb
  begin
    flag_set[0] = poison_log_en
                  & (txn_event_in.poison_cpl_rx
                     | txn_event_in.poison_req_tx);
    flag_set[1] = txn_event_in.cpl_abort_rx;
    flag_set[2] = txn_event_in.cpl_unsup_rx;
    flag_set[3] = syserr_en & txn_event_in.err_msg_tx;
    flag_set[4] = txn_event_in.poison_any_rx
                  | txn_event_in.poison_cpl_rx;
  end

  // ==========================================================
  // Sticky flag cells
  genvar gi;
  generate
    for (gi = 0; gi < nt_status_pkg::NUM_FLAGS; gi++)
    begin : g_flag
      assign flag_clr[gi] = wr_status_hi & wr_status_val[FLAG_POS[gi]];

      sticky_flag u_flag
      (
        .clk_in      (clk_in),
        .nrst_in     (nrst_in),
        .soft_clr_in (soft_rst_in),
        .set_in      (flag_set[gi]),
        .clr_in      (flag_clr[gi]),
        .flag_out    (flag_q[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Status word assembly
  logic [15:0] status_word;

  always_comb
  begin
    status_word = 16'h0000;
    status_word[nt_status_pkg::IRQ_PEND_BIT] = legacy_irq_pending_in;
    status_word[nt_status_pkg::CAP_CHAIN_BIT] =
      nt_status_pkg::CAP_CHAIN_VAL;
    status_word[nt_status_pkg::ABORT_SENT_BIT] = 1'h0;
    for (int i = 0; i < nt_status_pkg::NUM_FLAGS; i++)
    begin
      status_word[FLAG_POS[i]] = flag_q[i];
    end
  end

  // ==========================================================
  // Revision number, reset to REVISION_RST_VAL only by power-on reset
  logic [7:0] revision_r;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      revision_r <= nt_status_pkg::REVISION_RST_VAL;
    end
    else if (wr_rev & revision_unlock_in)
    begin
      revision_r <= cfg_req_in.wdata[REV_LANE*8 +: 8];
    end
  end

  // ==========================================================
  // Line size hint, storage only
  logic [7:0] line_size_r;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      line_size_r <= nt_status_pkg::LINE_RST_VAL;
    end
    else if (soft_rst_in)
    begin
      line_size_r <= nt_status_pkg::LINE_RST_VAL;
    end
    else if (wr_line)
    begin
      line_size_r <= cfg_req_in.wdata[LINE_LANE*8 +: 8];
    end
  end

  // ==========================================================
  // Read data mux
  logic [23:0] class_code;
  logic [31:0] rd_mux;

  assign class_code = {nt_status_pkg::BASE_CLASS_VAL,
                       nt_status_pkg::SUB_CLASS_VAL,
                       nt_status_pkg::PROG_IFACE_VAL};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_status)
    begin
      rd_mux[STS_LANE*8 +: 16] = status_word;
    end
    else if (hit_rev_class)
    begin
      rd_mux[REV_LANE*8 +: 8]  = revision_r;
      rd_mux[CLS_LANE*8 +: 24] = class_code;
    end
    else if (hit_line)
    begin
      rd_mux[LINE_LANE*8 +: 8] = line_size_r;
    end
  end

  // ==========================================================
  // Read answer, one cycle after the request
  logic [31:0] rdata_r;
  logic        rvalid_r;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'h0;
    end
    else
    begin
      rvalid_r <= cfg_req_in.rd;
      if (cfg_req_in.rd)
      begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign cfg_rdata_out  = rdata_r;
  assign cfg_rvalid_out = rvalid_r;

  // ==========================================================
  // Observation copies for neighbouring logic
  logic [15:0] status_obs_r;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      status_obs_r <= 16'h0000;
    end
    else
    begin
      status_obs_r <= status_word;
    end
  end

  assign function_status_word_out = status_obs_r;
  assign line_size_hint_out       = line_size_r;

endmodule

// [pkg/nt_status_pkg.sv]
// Constants and carrier types for the function status and class slice
package nt_status_pkg;

  // ==========================================================
  // Register byte offsets in the configuration header
  localparam logic [7:0] STATUS_OFS   = 8'h06;
  localparam logic [7:0] REVISION_OFS = 8'h08;
  localparam logic [7:0] CLASS_OFS    = 8'h09;
  localparam logic [7:0] LINE_OFS     = 8'h0C;

  // ==========================================================
  // Status word bit positions
  localparam int unsigned IRQ_PEND_BIT   = 3;
  localparam int unsigned CAP_CHAIN_BIT  = 4;
  localparam int unsigned REQ_POISON_BIT = 8;
  localparam int unsigned ABORT_SENT_BIT = 11;
  localparam int unsigned ABORT_RX_BIT   = 12;
  localparam int unsigned UNSUP_RX_BIT   = 13;
  localparam int unsigned SYSERR_BIT     = 14;
  localparam int unsigned POISON_DET_BIT = 15;

  // Command word enable positions
  localparam int unsigned CMD_POISON_LOG_BIT = 6;
  localparam int unsigned CMD_SYSERR_BIT     = 8;

  // ==========================================================
  // Constant and reset values
  localparam logic       CAP_CHAIN_VAL  = 1'h1;
  localparam logic [7:0] PROG_IFACE_VAL = 8'h00;
  localparam logic [7:0] SUB_CLASS_VAL  = 8'h80;
  localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
  localparam logic [7:0] LINE_RST_VAL   = 8'h00;
  // Arbitrary neutral revision value after power-on
  localparam logic [7:0] REVISION_RST_VAL = 8'h01;

  // Number of sticky flags held in cells
  localparam int unsigned NUM_FLAGS = 5;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic poison_cpl_rx;
    logic poison_req_tx;
    logic poison_any_rx;
    logic cpl_abort_rx;
    logic cpl_unsup_rx;
    logic err_msg_tx;
  } txn_event_t;

endpackage

// [hw/sticky_flag.sv]
// One hardware-set, write-one-to-clear status flag
`timescale 1ns/1ns
module sticky_flag
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic soft_clr_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);

  logic flag_r;

  // ==========================================================
  // Flag storage
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      flag_r <= 1'h0;
    end
    else if (soft_clr_in)
    begin
      flag_r <= 1'h0;
    end
    else if (set_in)
    begin
      flag_r <= 1'h1;
    end
    else if (clr_in)
    begin
      flag_r <= 1'h0;
    end
  end

  assign flag_out = flag_r;

endmodule

// [verification/txn_event_model.sv]
// Far-side transaction logic model issuing one-cycle event pulses
`timescale 1ns/1ns
module txn_event_model
(
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  input  wire nt_status_pkg::txn_event_t fire_in,
  output nt_status_pkg::txn_event_t      event_out
);
  // ==========================================================
  // Event pulses, quiet while in reset
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      event_out <= '0;
    else
      event_out <= fire_in;
  end
endmodule

// [verification/nt_status_sva.sv]
// Port checker for the status and class register slice
`timescale 1ns/1ns
module nt_status_sva
(
  input wire logic                      clk_in,
  input wire logic                      nrst_in,
  input wire logic                      soft_rst_in,
  input wire nt_status_pkg::cfg_req_t   cfg_req_in,
  input wire nt_status_pkg::txn_event_t txn_event_in,
  input wire logic [15:0]               function_command_word_in,
  input wire logic                      legacy_irq_pending_in,
  input wire logic                      cfg_rvalid_out,
  input wire logic [15:0]               function_status_word_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic        live_r;
  logic [15:0] st;
  assign st = function_status_word_out;
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
      live_r <= 1'b0;
    else
      live_r <= !soft_rst_in;
  property p_sets(e, b);
    (e && !soft_rst_in ##1 !soft_rst_in) |-> ##1 b;
  endproperty
  // ==========================================================
  // Assertions
  a_cap_bit_one: assert property (live_r |-> st[4])
    else $error("capability bit low");
  a_unused_zero: assert property
    (live_r |-> (st & 16'h06E7) == 16'h0000)
    else $error("unused status bits set");
  a_abort_sent_zero: assert property (st[11] == 1'b0)
    else $error("abort sent bit set");
  a_irq_mirror: assert property
    (live_r |-> st[3] == $past(legacy_irq_pending_in))
    else $error("irq pending bit wrong");
  a_abort_rx_set: assert property
    (p_sets(txn_event_in.cpl_abort_rx, st[12])) else $error("abort rx lost");
  a_unsup_rx_set: assert property
    (p_sets(txn_event_in.cpl_unsup_rx, st[13])) else $error("unsup rx lost");
  a_syserr_set: assert property (p_sets(txn_event_in.err_msg_tx
    && function_command_word_in[8], st[14])) else $error("syserr lost");
  a_poison_det_set: assert property (p_sets(txn_event_in.poison_any_rx
    || txn_event_in.poison_cpl_rx, st[15])) else $error("poison lost");
  a_req_poison_set: assert property
    (p_sets((txn_event_in.poison_cpl_rx || txn_event_in.poison_req_tx)
    && function_command_word_in[6], st[8]))
    else $error("req poison lost");
  a_req_poison_gate: assert property ($rose(st[8]) |-> $past(
    (txn_event_in.poison_cpl_rx || txn_event_in.poison_req_tx)
    && function_command_word_in[6], 2)) else $error("req poison unasked");
  a_syserr_gate: assert property ($rose(st[14]) |-> $past(
    txn_event_in.err_msg_tx && function_command_word_in[8], 2))
    else $error("syserr unasked");
  a_w1c_clear: assert property (cfg_req_in.wr && cfg_req_in.be[3]
    && cfg_req_in.addr[7:2] == 6'h01 && cfg_req_in.wdata[28]
    && !txn_event_in.cpl_abort_rx |-> ##2 !st[12]) else $error("no clear");
  a_read_answer: assert property (cfg_req_in.rd |=> cfg_rvalid_out)
    else $error("read not answered");
  c_set_clear: cover property (txn_event_in.cpl_abort_rx && cfg_req_in.wr);
  c_syserr: cover property ($rose(st[14]));
  c_read: cover property (cfg_rvalid_out);
endmodule
bind nt_function_status_class_regs nt_status_sva i_sva
(
  .clk_in                  (clk_in),
  .nrst_in                 (nrst_in),
  .soft_rst_in             (soft_rst_in),
  .cfg_req_in              (cfg_req_in),
  .txn_event_in            (txn_event_in),
  .function_command_word_in(function_command_word_in),
  .legacy_irq_pending_in   (legacy_irq_pending_in),
  .cfg_rvalid_out          (cfg_rvalid_out),
  .function_status_word_out(function_status_word_out)
);

// [verification/nt_function_status_class_regs_bench.sv]
// Self-checking bench for the status and class register slice
`timescale 1ns/1ns
module nt_function_status_class_regs_bench;
  logic                      clk_in = 1'b0;
  logic                      nrst_in = 1'b0;
  logic                      srst = 1'b0;
  logic                      irq = 1'b0;
  logic                      unlock = 1'b0;
  logic [15:0]               cmd = 16'h0000;
  logic [7:0]                rnd = 8'h24;
  logic [15:0]               flags;
  nt_status_pkg::cfg_req_t   req = '0;
  nt_status_pkg::txn_event_t fire = '0;
  nt_status_pkg::txn_event_t ev;
  logic                      hit;
  logic                      rvalid;
  logic [31:0]               rdata;
  logic [15:0]               st;
  logic [7:0]                line;
  int                        fail_count = 0;
  int                        checked = 0;
  always #10 clk_in = ~clk_in;
  txn_event_model i_far
  (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .fire_in  (fire),
    .event_out(ev)
  );
  nt_function_status_class_regs i_dut
  (
    .clk_in                  (clk_in),
    .nrst_in                 (nrst_in),
    .soft_rst_in             (srst),
    .cfg_req_in              (req),
    .txn_event_in            (ev),
    .function_command_word_in(cmd),
    .legacy_irq_pending_in   (irq),
    .revision_unlock_in      (unlock),
    .cfg_hit_out             (hit),
    .cfg_rdata_out           (rdata),
    .cfg_rvalid_out          (rvalid),
    .function_status_word_out(st),
    .line_size_hint_out      (line)
  );
  // ==========================================================
  // Helpers
  function automatic logic [7:0] nxt(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] expf(nt_status_pkg::txn_event_t f);
    expf = 16'h0010;
    expf[8] = (f.poison_cpl_rx | f.poison_req_tx) & cmd[6];
    expf[12] = f.cpl_abort_rx;
    expf[13] = f.cpl_unsup_rx;
    expf[14] = f.err_msg_tx & cmd[8];
    expf[15] = f.poison_any_rx | f.poison_cpl_rx;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [3:0] b, logic [31:0] d);
    req = '{1'b0, 1'b1, a, b, d};
    @(posedge clk_in) #1;
    req = '0;
    // Idle edge, so the next request is not set in this time step
    @(posedge clk_in) #1;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    req = '{1'b1, 1'b0, a, 4'h0, 32'h0000_0000};
    #1 chk("hit", {31'h0, a[7:2] inside {6'h01, 6'h02, 6'h03}}, {31'h0, hit});
    @(posedge clk_in) #1;
    req = '0;
    chk("rvalid", 32'h0000_0001, {31'h0, rvalid});
    chk("rdata", e, rdata);
    // Idle edge, so the next request is not set in this time step
    @(posedge clk_in) #1;
  endtask
  task automatic test_done;
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    repeat (6) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    @(posedge clk_in) #1;
    rd(8'h04, 32'h0010_0000);
    rd(8'h09, 32'h0680_0001);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    irq = 1'b1;
    rd(8'h06, 32'h0018_0000);
    irq = 1'b0;
    wr(8'h04, 4'hC, 32'h6FFF_FFFF);
    rd(8'h04, 32'h0010_0000);
    repeat (24)
    begin
      rnd = nxt(rnd);
      cmd = {7'h00, rnd[0], 1'b0, rnd[1], 6'h00};
      rnd = nxt(rnd);
      fire = nt_status_pkg::txn_event_t'(rnd[5:0]);
      flags = expf(fire);
      @(posedge clk_in) #1;
      fire = '0;
      @(posedge clk_in) #1;
      wr(8'h04, 4'hF, 32'h0000_0000);
      rd(8'h04, {flags, 16'h0000});
      chk("status", {16'h0, flags}, {16'h0, st});
      wr(8'h04, 4'h8, 32'hFFFF_FFFF);
      rd(8'h04, 32'h0010_0000);
    end
    fire = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    @(posedge clk_in) #1;
    fire = '0;
    wr(8'h04, 4'h8, 32'hFFFF_FFFF);
    rd(8'h04, 32'h1010_0000);
    wr(8'h08, 4'hF, 32'hFFFF_FFAB);
    rd(8'h08, 32'h0680_0001);
    unlock = 1'b1;
    wr(8'h08, 4'hF, 32'hFFFF_FF5A);
    rd(8'h08, 32'h0680_005A);
    wr(8'h0C, 4'h1, 32'hFFFF_FF3C);
    rd(8'h0C, 32'h0000_003C);
    chk("line", 32'h0000_003C, {24'h0, line});
    srst = 1'b1;
    @(posedge clk_in) #1;
    srst = 1'b0;
    rd(8'h08, 32'h0680_005A);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h04, 32'h0010_0000);
    test_done;
  end
  initial
  begin
    repeat (3000) @(posedge clk_in);
    fail_count++;
    test_done;
  end
endmodule
